// >>> core/lcd_supply_pkg.sv
// Purpose: constants and carrier types for the display supply control block
// Assumes: classic Wishbone slave, byte address = register index * 4
// Notes: Functional notes below list the behaviour this block keeps
//
// Functional notes
// R1 - ladder select resets to zero (charge pump); one selects external ladder
// R2 - charge pump selected and display off: voltage generation fully off
// R3 - six-bit bias level picks one of 64 pump levels for contrast
// R4 - external ladder selected: no bias compensation, bias level ignored
// R5 - in deep sleep display is on only if sleep-off 0, enable 1
// R6 - software enables the voltage reference before deep sleep display use
// R7 - configuration and segment memory stay intact while display is off
// R8 - segment pins zero to fifteen are always segment lines
// R9 - four-way mux: all four commons active, shared common pins not segments
// R10 - a shared pin becomes a segment only when its enable bit is set
// R11 - display starts driving when software sets the display enable bit
// R12 - freeze bit holds the shown data; new data shows after clearing
// R13 - pointer write, top bit set stores data; clear loads data register
// R14 - source, bias and sleep gating act only through clocked registers
package lcd_supply_pkg;

  // -------------------------------------------------------------------
  // register indices (byte address is index * 4)
  // -------------------------------------------------------------------
  localparam logic [7:0] IDX_DISPLAY_CONTROL  = 8'h95;
  localparam logic [7:0] IDX_SEG_PIN_ENABLE   = 8'h97;
  localparam logic [7:0] IDX_SUPPLY_CONFIG    = 8'h9c;
  localparam logic [7:0] IDX_SEGMENT_POINTER  = 8'hac;
  localparam logic [7:0] IDX_SEGMENT_DATA     = 8'hae;
  localparam logic [7:0] IDX_DISPLAY_CONFIG_Y = 8'hb1;
  localparam logic [7:0] IDX_SEG_PIN_ENABLE2  = 8'hed;
  localparam logic [7:0] REG_RESET            = 8'h00;

  // -------------------------------------------------------------------
  // field layout
  // -------------------------------------------------------------------
  localparam int         DC_ENABLE_BIT    = 0;
  localparam int         DC_SLEEP_OFF_BIT = 1;
  localparam int         DC_MUX_LSB       = 2;
  localparam logic [1:0] MUX_FOUR         = 2'h3;
  localparam int         SC_LADDER_BIT    = 7;
  localparam int         BIAS_W           = 6;
  localparam int         CY_FREEZE_BIT    = 0;
  localparam int         PTR_WRITE_BIT    = 7;
  localparam int         PTR_ADDR_W       = 6;

  // -------------------------------------------------------------------
  // pin map and memory size
  // -------------------------------------------------------------------
  localparam int NUM_SEG_PINS   = 29;
  localparam int FIXED_SEG      = 16;
  localparam int SEG_EN_BASE    = 20;
  localparam int SEG_EN_COUNT   = 8;
  localparam int SEG_EN2_BASE   = 16;
  localparam int SEG_EN2_COUNT  = 4;
  localparam int SEG_EN2_TOP    = 4;
  localparam int PIN_COMMON_LINE_THREE_SHARE = 27;
  localparam int PIN_COMMON_LINE_TWO_SHARE = 28;
  localparam int NUM_COMS       = 4;
  localparam int MEM_DEPTH      = 64;

  // -------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic              pump_enable;
    logic              ladder_enable;
    logic              bias_apply;
    logic [BIAS_W-1:0] bias_level;
  } supply_ctl_t;

endpackage

// >>> core/lcd_supply_power_control.sv
// Purpose: display supply, sleep gating, pin function and segment memory
// Assumes: single 250 MHz clock; scan address comes from same-clock logic
// Notes: deep sleep level arrives asynchronously and is synchronised
`timescale 1ns/1ns
module lcd_supply_power_control (
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  // wishbone slave
  input  wire lcd_supply_pkg::wb_req_t     wb_req_in,
  output logic                             wb_ack_out,
  output logic [31:0]                      wb_dat_out,
  // power mode
  input  wire logic                        deep_sleep_mode_in,
  // panel side
  input  wire logic [5:0]                  scan_addr_in,
  output logic [7:0]                       scan_data_out,
  output lcd_supply_pkg::supply_ctl_t      supply_out,
  output logic                             display_on_out,
  output logic [lcd_supply_pkg::NUM_SEG_PINS-1:0] seg_func_out,
  output logic [lcd_supply_pkg::NUM_COMS-1:0]     com_active_out
);
  import lcd_supply_pkg::*;

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  logic [7:0]  ctrl_q;
  logic [7:0]  seg_en_q;
  logic [7:0]  seg_en2_q;
  logic [7:0]  supply_q;
  logic [7:0]  cfg_y_q;
  logic [7:0]  pointer_q;
  logic [7:0]  data_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        ds_meta_q;
  logic        ds_sync_q;
  logic [5:0]  refresh_q;
  logic [7:0]  work_mem [MEM_DEPTH];
  logic [7:0]  shown_mem [MEM_DEPTH];
  logic [7:0]  scan_q;
  supply_ctl_t supply_ctl_q;
  supply_ctl_t supply_d;
  logic        disp_on_q;
  logic        disp_on_d;
  logic [NUM_SEG_PINS-1:0] seg_q;
  logic [NUM_SEG_PINS-1:0] seg_d;
  logic [NUM_COMS-1:0]     com_q;
  logic [7:0]  index;
  logic        wr_fire;
  logic        ptr_fire;
  logic [1:0]  mux;
  logic        ladder;
  logic        freeze;

  // decodes the mux field into active common lines
  function automatic logic [NUM_COMS-1:0] com_mask(input logic [1:0] m);
    logic [NUM_COMS-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_COMS; i++) begin
      if (i <= int'(m)) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  // -------------------------------------------------------------------
  // bus decode
  // -------------------------------------------------------------------
  // write lands on the edge where the master sees ack high
  assign index    = wb_req_in.adr[9:2];
  assign wr_fire  = wb_req_in.cyc & wb_req_in.stb & wb_req_in.we & ack_q
                    & wb_req_in.sel[0];
  assign ptr_fire = wr_fire & (index == IDX_SEGMENT_POINTER);
  assign mux      = ctrl_q[DC_MUX_LSB +: 2];
  assign ladder   = supply_q[SC_LADDER_BIT];
  assign freeze   = cfg_y_q[CY_FREEZE_BIT];

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req_in.cyc & wb_req_in.stb & ~ack_q;
    end
  end

  // read data captured with the ack; unmapped reads return zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdat_q <= '0;
    end else if (wb_req_in.cyc & wb_req_in.stb & ~ack_q) begin
      case (index)
        IDX_DISPLAY_CONTROL:  rdat_q <= {24'h000000, ctrl_q};
        IDX_SEG_PIN_ENABLE:   rdat_q <= {24'h000000, seg_en_q};
        IDX_SUPPLY_CONFIG:    rdat_q <= {24'h000000, supply_q};
        IDX_SEGMENT_POINTER:  rdat_q <= {24'h000000, pointer_q};
        IDX_SEGMENT_DATA:     rdat_q <= {24'h000000, data_q};
        IDX_DISPLAY_CONFIG_Y: rdat_q <= {24'h000000, cfg_y_q};
        IDX_SEG_PIN_ENABLE2:  rdat_q <= {24'h000000, seg_en2_q};
        default:              rdat_q <= '0;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // configuration registers
  // -------------------------------------------------------------------
  // plain storage; nothing here is cleared by display off
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_q    <= REG_RESET;
      seg_en_q  <= REG_RESET;
      seg_en2_q <= REG_RESET;
      supply_q  <= REG_RESET; // R1
      cfg_y_q   <= REG_RESET;
      pointer_q <= REG_RESET;
    end else if (wr_fire) begin // R7
      case (index)
        IDX_DISPLAY_CONTROL:  ctrl_q    <= wb_req_in.dat[7:0]; // R11
        IDX_SEG_PIN_ENABLE:   seg_en_q  <= wb_req_in.dat[7:0];
        IDX_SUPPLY_CONFIG:    supply_q  <= wb_req_in.dat[7:0]; // R1
        IDX_SEGMENT_POINTER:  pointer_q <= wb_req_in.dat[7:0];
        IDX_DISPLAY_CONFIG_Y: cfg_y_q   <= wb_req_in.dat[7:0];
        IDX_SEG_PIN_ENABLE2:  seg_en2_q <= wb_req_in.dat[7:0];
        default:              ;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // segment memory access through pointer and data registers
  // -------------------------------------------------------------------
  // data register: bus write, or load from memory on a pointer read
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_q <= REG_RESET;
    end else if (wr_fire && index == IDX_SEGMENT_DATA) begin
      data_q <= wb_req_in.dat[7:0];
    end else if (ptr_fire && !wb_req_in.dat[PTR_WRITE_BIT]) begin
      data_q <= work_mem[wb_req_in.dat[PTR_ADDR_W-1:0]]; // R13
    end
  end

  // working memory: stored on a pointer write with the top bit set
  always_ff @(posedge clk_in) begin
    if (ptr_fire && wb_req_in.dat[PTR_WRITE_BIT]) begin
      work_mem[wb_req_in.dat[PTR_ADDR_W-1:0]] <= data_q; // R13
    end
  end

  // round-robin copy into the shown memory, paused while frozen
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      refresh_q <= '0;
    end else begin
      refresh_q <= refresh_q + 6'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!freeze) begin
      shown_mem[refresh_q] <= work_mem[refresh_q]; // R12
    end
  end

  // panel scan read of the shown data
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scan_q <= REG_RESET;
    end else begin
      scan_q <= shown_mem[scan_addr_in];
    end
  end

  // -------------------------------------------------------------------
  // deep sleep synchroniser
  // -------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ds_meta_q <= 1'b0;
      ds_sync_q <= 1'b0;
    end else begin
      ds_meta_q <= deep_sleep_mode_in;
      ds_sync_q <= ds_meta_q;
    end
  end

  // -------------------------------------------------------------------
  // supply, gating and pin function
  // -------------------------------------------------------------------
  // display on; sleep-off only matters in deep sleep
  always_comb begin
    disp_on_d = ctrl_q[DC_ENABLE_BIT]; // R11
    if (ds_sync_q && ctrl_q[DC_SLEEP_OFF_BIT]) begin
      disp_on_d = 1'b0; // R5
    end
  end

  // pump runs only when selected and display on; ladder gets no bias
  always_comb begin
    supply_d               = '0;
    supply_d.ladder_enable = ladder; // R1
    if (!ladder) begin
      supply_d.pump_enable = disp_on_d; // R2
      supply_d.bias_apply  = disp_on_d;
      // level is held at zero while the pump is stopped
      if (disp_on_d) begin
        supply_d.bias_level = supply_q[BIAS_W-1:0]; // R3
      end
    end // R4
  end

  // fixed segments, enabled shared pins, commons taken in four-way
  always_comb begin
    seg_d                = '0;
    seg_d[FIXED_SEG-1:0] = '1; // R8
    for (int i = 0; i < SEG_EN_COUNT; i++) begin
      seg_d[SEG_EN_BASE+i] = seg_en_q[i]; // R10
    end
    for (int i = 0; i < SEG_EN2_COUNT; i++) begin
      seg_d[SEG_EN2_BASE+i] = seg_en2_q[i]; // R10
    end
    seg_d[PIN_COMMON_LINE_TWO_SHARE] = seg_en2_q[SEG_EN2_TOP]; // R10
    if (mux == MUX_FOUR) begin
      seg_d[PIN_COMMON_LINE_THREE_SHARE] = 1'b0; // R9
      seg_d[PIN_COMMON_LINE_TWO_SHARE] = 1'b0; // R9
    end
  end

  // every control output is registered
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      supply_ctl_q <= '0;
      disp_on_q    <= 1'b0;
      seg_q        <= {{(NUM_SEG_PINS-FIXED_SEG){1'b0}}, {FIXED_SEG{1'b1}}};
      com_q        <= 4'h1;
    end else begin
      supply_ctl_q <= supply_d; // R14
      disp_on_q    <= disp_on_d; // R14
      seg_q        <= seg_d;
      com_q        <= com_mask(mux); // R9
    end
  end

  assign wb_ack_out     = ack_q;
  assign wb_dat_out     = rdat_q;
  assign scan_data_out  = scan_q;
  assign supply_out     = supply_ctl_q;
  assign display_on_out = disp_on_q;
  assign seg_func_out   = seg_q;
  assign com_active_out = com_q;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_ladder_source: assert property ( // R1
    ladder |=> supply_out.ladder_enable && !supply_out.pump_enable)
    else $error("ladder selected but pump runs");

  a_pump_gated_off: assert property ( // R2
    !ladder && !ctrl_q[DC_ENABLE_BIT] |=> !supply_out.pump_enable)
    else $error("pump on while display disabled");

  a_bias_level_out: assert property ( // R3
    !ladder && disp_on_d |=> supply_out.bias_level == $past(supply_q[5:0]))
    else $error("bias level not passed to pump");

  a_no_ladder_bias: assert property ( // R4
    supply_out.ladder_enable |-> !supply_out.bias_apply
                                 && supply_out.bias_level == 6'h00)
    else $error("bias applied with external ladder");

  a_sleep_gate: assert property ( // R5
    ds_sync_q && ctrl_q[DC_SLEEP_OFF_BIT] |=> !display_on_out)
    else $error("display on in deep sleep with sleep-off set");

  a_fixed_segments: assert property ( // R8
    seg_func_out[15:0] == 16'hffff)
    else $error("fixed segment pin lost segment duty");

  a_four_way_coms: assert property ( // R9
    mux == MUX_FOUR |=> com_active_out == 4'hf && seg_func_out[28:27] == 2'h0)
    else $error("four-way mux pin map wrong");

  a_shared_pin_en: assert property ( // R10
    $rose(seg_func_out[20]) |-> $past(seg_en_q[0]))
    else $error("shared pin became segment without enable");

  a_enable_start: assert property ( // R11
    wr_fire && index == IDX_DISPLAY_CONTROL && wb_req_in.dat[0]
    && !wb_req_in.dat[1] |=> ##1 display_on_out)
    else $error("display did not start after enable");

  a_freeze_hold: assert property ( // R12
    freeze ##1 freeze && $stable(scan_addr_in) |=> $stable(scan_data_out))
    else $error("shown data changed while frozen");

  a_pointer_store: assert property ( // R13
    ptr_fire && wb_req_in.dat[7] && !(wr_fire && index == IDX_SEGMENT_DATA)
    |=> work_mem[$past(wb_req_in.dat[5:0])] == $past(data_q))
    else $error("pointer write did not store data");

  // gating and supply consistency
  a_dark_disabled: assert property ( // R5
    !ctrl_q[DC_ENABLE_BIT] |=> !display_on_out)
    else $error("display on with enable bit clear");

  a_awake_display: assert property ( // R11
    ctrl_q[DC_ENABLE_BIT] && !ds_sync_q |=> display_on_out)
    else $error("display off while enabled and awake");

  a_pump_needs_on: assert property ( // R2
    supply_out.pump_enable |-> display_on_out && !supply_out.ladder_enable)
    else $error("pump runs with display off or ladder selected");

  a_bias_idle_zero: assert property ( // R2
    !supply_out.pump_enable |-> !supply_out.bias_apply
                                && supply_out.bias_level == '0)
    else $error("bias driven while pump stopped");

  // register retention and pin map
  a_config_kept: assert property ( // R7
    !wr_fire && !display_on_out |=> $stable(ctrl_q) && $stable(supply_q)
    && $stable(seg_en_q) && $stable(seg_en2_q))
    else $error("configuration changed while display off");

  a_pin_enable_one: assert property ( // R10
    seg_func_out[SEG_EN_BASE +: SEG_EN_COUNT-1]
    == $past(seg_en_q[SEG_EN_COUNT-2:0]))
    else $error("first enable register pin map wrong");

  a_pin_enable_two: assert property ( // R10
    seg_func_out[SEG_EN2_BASE +: SEG_EN2_COUNT]
    == $past(seg_en2_q[SEG_EN2_COUNT-1:0]))
    else $error("second enable register pin map wrong");

  // segment memory load
  a_pointer_load: assert property ( // R13
    ptr_fire && !wb_req_in.dat[PTR_WRITE_BIT]
    |=> data_q == work_mem[$past(wb_req_in.dat[PTR_ADDR_W-1:0])])
    else $error("pointer read did not load data register");

endmodule

// >>> dv/panel_model.sv
// Purpose: segment panel stand-in that scans one memory byte and latches it
// Assumes: same clock as the block; scan address is chosen by the bench
// Notes: the panel only reads; it never writes back into the block
`timescale 1ns/1ns
module panel_model (
  // clock
  input  wire logic       clk_in,
  // bench side
  input  wire logic [5:0] want_in,
  output logic      [7:0] seen_out,
  // block side
  output logic      [5:0] scan_addr_out,
  input  wire logic [7:0] scan_data_in
);
  // ---------------------------------------------------------------
  // scan
  // ---------------------------------------------------------------
  // address leaves on the edge, the byte returns one edge later
  always_ff @(posedge clk_in) begin
    scan_addr_out <= want_in;
    seen_out      <= scan_data_in;
  end
endmodule

// >>> dv/tb_lcd_supply_power_control.sv
// Purpose: register level checks of supply, sleep, pin and memory control
// Assumes: one-cycle registered ack, register index in adr[9:2]
// Notes: settle waits follow the hand-over latencies plus margin
`timescale 1ns/1ns
module tb_lcd_supply_power_control;
  import lcd_supply_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        deep_sleep_mode_in = 1'b0;
  wb_req_t     req = '0;
  logic        wb_ack_out;
  logic [31:0] wb_dat_out;
  logic [5:0]  scan_addr;
  logic [7:0]  scan_data;
  logic [5:0]  want = 6'h05;
  logic [7:0]  seen;
  supply_ctl_t supply;
  logic        display_on;
  logic [28:0] seg_func;
  logic [3:0]  com_active;
  logic [31:0] rd;
  int          errors = 0;
  int          compares = 0;

  always #2 clk_in = ~clk_in;

  lcd_supply_power_control u_lcd_supply_power_control (
    .clk_in(clk_in), .rst_in(rst_in), .wb_req_in(req),
    .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
    .deep_sleep_mode_in(deep_sleep_mode_in), .scan_addr_in(scan_addr),
    .scan_data_out(scan_data), .supply_out(supply),
    .display_on_out(display_on), .seg_func_out(seg_func),
    .com_active_out(com_active));

  panel_model u_panel_model (
    .clk_in(clk_in), .want_in(want), .seen_out(seen),
    .scan_addr_out(scan_addr), .scan_data_in(scan_data));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // one classic cycle; holds the request until ack is sampled
  task automatic wb(input logic we, input logic [7:0] idx,
                    input logic [7:0] d);
    @(posedge clk_in);
    req.cyc <= 1'b1;
    req.stb <= 1'b1;
    req.we  <= we;
    req.adr <= {idx, 2'h0};
    req.sel <= 4'h1;
    req.dat <= {24'h0, d};
    // wait for ack as long as it takes; only the watchdog ends this
    do begin
      @(posedge clk_in);
    end while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic check(input string name, input logic [31:0] s,
                       input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic conclude;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial begin
    #20000;
    errors++;
    conclude();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    idle(20);
    rst_in <= 1'b0;
    check("supply", {23'h0, supply}, 32'h0);
    check("seg_func", {3'h0, seg_func}, 32'h0000ffff);
    check("com", {28'h0, com_active}, 32'h1);
    wb(1'b0, IDX_SUPPLY_CONFIG, 8'h00);
    check("supply_rd", rd, 32'h0);
    wb(1'b0, 8'h00, 8'h00);
    check("unmapped", rd, 32'h0);
    // pump selected, display still off: no generation
    wb(1'b1, IDX_SUPPLY_CONFIG, 8'h2e);
    idle(4);
    check("pump_off", {23'h0, supply}, 32'h0);
    wb(1'b1, IDX_DISPLAY_CONTROL, 8'h01);
    idle(4);
    check("disp_on", {31'h0, display_on}, 32'h1);
    check("pump_on", {23'h0, supply}, 32'h16e);
    wb(1'b1, IDX_SUPPLY_CONFIG, 8'hae);
    idle(4);
    check("ladder", {23'h0, supply}, 32'h080);
    wb(1'b1, IDX_SUPPLY_CONFIG, 8'h2e);
    // deep sleep gating; the voltage reference is taken as enabled first
    deep_sleep_mode_in <= 1'b1;
    idle(6);
    check("sleep_on", {31'h0, display_on}, 32'h1);
    wb(1'b1, IDX_DISPLAY_CONTROL, 8'h03);
    idle(6);
    check("sleep_off", {31'h0, display_on}, 32'h0);
    check("sleep_pump", {23'h0, supply}, 32'h0);
    deep_sleep_mode_in <= 1'b0;
    idle(6);
    check("awake", {31'h0, display_on}, 32'h1);
    wb(1'b1, IDX_DISPLAY_CONTROL, 8'h00);
    wb(1'b0, IDX_SUPPLY_CONFIG, 8'h00);
    check("kept", rd, 32'h2e);
    // shared pins and four-way commons
    wb(1'b1, IDX_SEG_PIN_ENABLE, 8'h01);
    wb(1'b1, IDX_SEG_PIN_ENABLE2, 8'h10);
    idle(4);
    check("seg_one", {3'h0, seg_func}, 32'h1010ffff);
    wb(1'b1, IDX_SEG_PIN_ENABLE, 8'hff);
    wb(1'b1, IDX_SEG_PIN_ENABLE2, 8'h1f);
    wb(1'b1, IDX_DISPLAY_CONTROL, 8'h01);
    idle(4);
    check("seg_all", {3'h0, seg_func}, 32'h1fffffff);
    wb(1'b1, IDX_DISPLAY_CONTROL, 8'h0d);
    idle(4);
    check("seg_4way", {3'h0, seg_func}, 32'h07ffffff);
    check("com_4way", {28'h0, com_active}, 32'hf);
    // segment memory, freeze and pointer directions
    wb(1'b1, IDX_SEGMENT_DATA, 8'h3c);
    wb(1'b1, IDX_SEGMENT_POINTER, 8'h85);
    idle(70);
    check("shown", {24'h0, seen}, 32'h3c);
    wb(1'b1, IDX_DISPLAY_CONFIG_Y, 8'h01);
    wb(1'b1, IDX_SEGMENT_DATA, 8'hc3);
    wb(1'b1, IDX_SEGMENT_POINTER, 8'h85);
    idle(70);
    check("frozen", {24'h0, seen}, 32'h3c);
    wb(1'b1, IDX_SEGMENT_DATA, 8'h00);
    wb(1'b1, IDX_SEGMENT_POINTER, 8'h05);
    wb(1'b0, IDX_SEGMENT_DATA, 8'h00);
    check("readback", rd, 32'hc3);
    wb(1'b1, IDX_DISPLAY_CONFIG_Y, 8'h00);
    idle(70);
    check("thawed", {24'h0, seen}, 32'hc3);
    conclude();
  end
endmodule
